// ===== rtl/ms_tick.sv
// Millisecond enable divider
`timescale 1ns/1ns
module ms_tick #(
    parameter int CYC_PER_MS = 20000
) (
    input  wire logic i_mclk,
    input  wire logic i_rst_b,
    input  wire logic i_run,
    output logic      o_tick
);
    logic [15:0] cnt_r;
    logic [15:0] cnt_nxt;
    logic        tick_nxt;

    // Restart on every run rise so the first tick is a whole ms away
    always_comb begin
        cnt_nxt  = 16'h0000;
        tick_nxt = 1'b0;
        if (i_run) begin
            if (cnt_r == 16'(CYC_PER_MS - 1)) begin
                tick_nxt = 1'b1;
            end else begin
                cnt_nxt = cnt_r + 16'h0001;
            end
        end
    end

    always_ff @(posedge i_mclk) begin
        if (!i_rst_b) begin
            cnt_r  <= 16'h0000;
            o_tick <= 1'b0;
        end else begin
            cnt_r  <= cnt_nxt;
            o_tick <= tick_nxt;
        end
    end
endmodule : ms_tick

// ===== rtl/ref_clock_params.svh
// Constants for reference clock start-up and frequency configuration
// Functional notes
// - Wait 5 ms after clock request before firmware
// - Setting 1-31 ms sets the start-up wait
// - Setting zero selects the standard 5 ms
// - Frequency setting counts 1 kHz units
// - Unconfigured frequency defaults to 26000
// - Accept 250 kHz multiples in 12-52 MHz and cellular values
// - Loop locks to reference, 32.768k or 1k
// - Digital clock identical whichever source locked
// - Radio waits 6 ms after firmware start
`ifndef REF_CLOCK_PARAMS_SVH
`define REF_CLOCK_PARAMS_SVH
`define CLK_HZ            20000000
`define MS_PER_S          1000
`define STD_WAIT_MS       5
`define RADIO_HOLD_MS     6
`define CYC_PER_MS        (`CLK_HZ / `MS_PER_S)
`define FREQ_DEFAULT_KHZ  16'd26000
`define FREQ_STEP_KHZ     250
`define FREQ_MIN_KHZ      12000
`define FREQ_MAX_KHZ      52000
`define SRC_REF           2'd0
`define SRC_WD_EXT        2'd1
`define SRC_WD_INT        2'd2
`endif

// ===== rtl/ref_clock_pkg.sv
// Types for reference clock start-up block
package ref_clock_pkg;
    typedef enum logic [1:0] {
        ST_IDLE  = 2'b00,
        ST_WAIT  = 2'b01,
        ST_RUN   = 2'b11,
        ST_RADIO = 2'b10
    } startup_state_e;
endpackage : ref_clock_pkg

// ===== rtl/ref_clock_startup_config.sv
// Start-up wait sequencer and reference frequency selection
`timescale 1ns/1ns
`include "ref_clock_params.svh"
module ref_clock_startup_config
    import ref_clock_pkg::*;
#(
    parameter int CYC_PER_MS = `CYC_PER_MS
) (
    input  wire logic        i_mclk,
    input  wire logic        i_rst_b,
    input  wire logic        i_wake,
    input  wire logic [4:0]  i_startup_wait_setting,
    input  wire logic [15:0] i_ref_frequency_setting,
    input  wire logic        i_freq_configured,
    input  wire logic [1:0]  i_lock_source,
    output logic             o_clk_request,
    output logic             o_fw_run,
    output logic             o_radio_enable,
    output logic [15:0]      o_ref_freq_khz,
    output logic             o_freq_supported,
    output logic [1:0]       o_loop_source
);
    startup_state_e state_r, state_nxt;
    logic [4:0]  ms_r, ms_nxt;
    logic [4:0]  target_ms;
    logic        tick;
    logic [15:0] freq_nxt;
    logic        sup_nxt;
    logic [1:0]  src_nxt;
    logic [31:0] dwell_r;
    logic [31:0] dwell_nxt;

    ms_tick #(.CYC_PER_MS(CYC_PER_MS)) u_tick (
        .i_mclk (i_mclk),
        .i_rst_b(i_rst_b),
        .i_run  (state_r == ST_WAIT || state_r == ST_RUN),
        .o_tick (tick)
    );

    // Zero means the standard wait, else the setting in ms
    assign target_ms = (i_startup_wait_setting == 5'h00) ? 5'(`STD_WAIT_MS)
                                                         : i_startup_wait_setting;

    // Sequencer: request, wait, firmware, radio hold-off
    always_comb begin
        state_nxt = state_r;
        ms_nxt    = ms_r;
        case (state_r)
            ST_IDLE: begin
                ms_nxt = 5'h00;
                if (i_wake) begin
                    state_nxt = ST_WAIT;
                end
            end
            ST_WAIT: begin
                if (tick) begin
                    if (ms_r + 5'h01 >= target_ms) begin
                        state_nxt = ST_RUN;
                        ms_nxt    = 5'h00;
                    end else begin
                        ms_nxt = ms_r + 5'h01;
                    end
                end
            end
            ST_RUN: begin
                if (tick) begin
                    if (ms_r + 5'h01 >= 5'(`RADIO_HOLD_MS)) begin
                        state_nxt = ST_RADIO;
                        ms_nxt    = 5'h00;
                    end else begin
                        ms_nxt = ms_r + 5'h01;
                    end
                end
            end
            ST_RADIO: state_nxt = ST_RADIO;
            default:  state_nxt = ST_IDLE;
        endcase
    end

    // Frequency checks; unsupported values still pass so firmware can report them
    always_comb begin
        freq_nxt = i_freq_configured ? i_ref_frequency_setting : `FREQ_DEFAULT_KHZ;
        case (freq_nxt)
            16'd14400, 16'd15360, 16'd16200, 16'd16800, 16'd19200,
            16'd19440, 16'd19680, 16'd19800, 16'd38400: sup_nxt = 1'b1;
            default: sup_nxt = (freq_nxt % 16'(`FREQ_STEP_KHZ) == 16'h0000)
                            && (freq_nxt >= 16'(`FREQ_MIN_KHZ))
                            && (freq_nxt <= 16'(`FREQ_MAX_KHZ));
        endcase
        // Illegal source code falls back to the reference
        src_nxt = (i_lock_source == `SRC_WD_EXT || i_lock_source == `SRC_WD_INT)
                ? i_lock_source : `SRC_REF;
    end

    // Sequencer registers
    always_ff @(posedge i_mclk) begin
        if (!i_rst_b) begin
            state_r <= ST_IDLE;
            ms_r    <= 5'h00;
        end else begin
            state_r <= state_nxt;
            ms_r    <= ms_nxt;
        end
    end

    // Frequency and source registers: outputs trail the inputs by one cycle
    always_ff @(posedge i_mclk) begin
        if (!i_rst_b) begin
            o_ref_freq_khz   <= `FREQ_DEFAULT_KHZ;
            o_freq_supported <= 1'b1;
            o_loop_source    <= `SRC_REF;
        end else begin
            o_ref_freq_khz   <= freq_nxt;
            o_freq_supported <= sup_nxt;
            o_loop_source    <= src_nxt;
        end
    end

    // Cycles spent in the present state; read only by the length checks,
    // so synthesis drops it
    always_comb begin
        dwell_nxt = dwell_r + 32'h0000_0001;
        if (state_nxt != state_r) begin
            dwell_nxt = 32'h0000_0000;
        end
    end

    // Dwell register; wraps harmlessly once the sequence has settled
    always_ff @(posedge i_mclk) begin
        if (!i_rst_b) begin
            dwell_r <= 32'h0000_0000;
        end else begin
            dwell_r <= dwell_nxt;
        end
    end

    // Request stays up from wake onward; run only after expiry
    assign o_clk_request  = (state_r != ST_IDLE);
    assign o_fw_run       = (state_r == ST_RUN) || (state_r == ST_RADIO);
    assign o_radio_enable = (state_r == ST_RADIO);

    // Wake taken in idle; sampled reset keeps the release edge out
    sequence seq_wake_taken;
        i_rst_b && state_r == ST_IDLE && i_wake;
    endsequence

    // Request up while firmware and radio are still held off
    sequence seq_req_held;
        o_clk_request && !o_fw_run && !o_radio_enable;
    endsequence

    // Last millisecond of the wait closes on this tick
    sequence seq_wait_expiry;
        state_r == ST_WAIT && tick && (ms_r + 5'h01 >= target_ms);
    endsequence

    // Firmware running, radio still held off
    sequence seq_fw_started;
        o_clk_request && o_fw_run && !o_radio_enable;
    endsequence

    // Run may not start while no request has been raised
    chk_run_needs_req: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
        o_fw_run |-> o_clk_request) else $error("run without clock request");
    // Run rises the cycle after a tick taken in the wait state
    chk_run_at_expiry: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
        $rose(o_fw_run) |-> $past(tick) && $past(state_r == ST_WAIT)) else $error("run rose early");
    // Radio rises only out of the run state on a tick
    chk_radio_after_run: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
        $rose(o_radio_enable) |-> $past(o_fw_run) && $past(tick)) else $error("radio early");
    // Default frequency when unconfigured
    chk_freq_default: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
        !i_freq_configured |=> o_ref_freq_khz == 16'd26000) else $error("default freq wrong");
    // Configured value passes through as kHz count
    chk_freq_pass: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
        i_freq_configured |=> o_ref_freq_khz == $past(i_ref_frequency_setting)) else $error("freq not kept");
    // Cellular value accepted
    chk_cell_ok: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
        (i_freq_configured && i_ref_frequency_setting == 16'd19440) |=> o_freq_supported)
        else $error("cellular rejected");
    // Zero setting gives the standard wait; dwell is one short of the cycles spent
    chk_zero_is_std: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
        ($rose(o_fw_run) && $past(i_startup_wait_setting) == 5'h00)
        |-> $past(dwell_r) == 32'(`STD_WAIT_MS * CYC_PER_MS)) else $error("zero wait not standard");

    // A set value sets the wait to that many milliseconds
    chk_set_wait_len: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
        ($rose(o_fw_run) && $past(i_startup_wait_setting) != 5'h00)
        |-> $past(dwell_r) == 32'($past(i_startup_wait_setting)) * 32'(CYC_PER_MS))
        else $error("set wait length wrong");

    // Radio waits the full hold after firmware start
    chk_radio_hold: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
        $rose(o_radio_enable) |-> $past(dwell_r) == 32'(`RADIO_HOLD_MS * CYC_PER_MS - 1))
        else $error("radio hold length wrong");

    // Wake taken in idle raises the request next cycle, firmware still held
    chk_wake_to_request: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
        seq_wake_taken |=> seq_req_held) else $error("request not raised on wake");

    // No early run: every cycle of the wait short of expiry keeps firmware held
    chk_wait_holds_fw: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
        (state_r == ST_WAIT && !(tick && ms_r + 5'h01 >= target_ms)) |=> seq_req_held)
        else $error("firmware ran inside the wait");

    // Expiry tick starts firmware on the next cycle
    chk_expiry_to_run: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
        seq_wait_expiry |=> seq_fw_started) else $error("run missed at expiry");

    // Request and run stand until reset; the sequence is one-shot
    chk_req_stands: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
        o_clk_request |=> o_clk_request) else $error("request dropped");

    chk_run_stands: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
        o_fw_run |=> o_fw_run) else $error("run dropped");

    // Legal source codes pass to the loop select unchanged
    chk_src_follows: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
        (i_rst_b && i_lock_source != 2'h3) |=> o_loop_source == $past(i_lock_source))
        else $error("loop source not kept");

    // Settings above the band are reported as unsupported
    chk_freq_above_max: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
        (i_rst_b && i_freq_configured && i_ref_frequency_setting > 16'(`FREQ_MAX_KHZ)) |=> !o_freq_supported)
        else $error("out of band accepted");

    // Unconfigured default is always a supported reference
    chk_default_supported: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
        !i_freq_configured |=> o_freq_supported) else $error("default not supported");

    // Loop source always legal
    chk_src_legal: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
        o_loop_source != 2'd3) else $error("bad loop source");
endmodule : ref_clock_startup_config

// ===== verif/ref_osc_model.sv
// Behavioural reference oscillator on the far side of the start-up block
`timescale 1ns/1ns
module ref_osc_model #(
    parameter int FREQ_KHZ = 38400
) (
    input  wire logic   i_clk_request,
    output logic [15:0] o_freq_khz,
    output logic        o_ref_clk
);
    // Offered rate lies in the 12-52 MHz band and matches the setting
    assign o_freq_khz = 16'(FREQ_KHZ);
    // Oscillates only while requested, stands still otherwise
    initial o_ref_clk = 1'b0;
    always #13 if (i_clk_request) o_ref_clk = ~o_ref_clk;
endmodule : ref_osc_model

// ===== verif/tb_ref_clock_startup_config.sv
// Self-checking bench for the start-up wait and frequency selection
`timescale 1ns/1ns
`define CHK(n, e, g) begin checked++; if ((g) !== (e)) begin num_errors++; \
    $display("[FAIL] %s exp %0d got %0d", n, e, g); end end
module tb_ref_clock_startup_config;
    import ref_clock_pkg::*;
    localparam int CPM = 10;
    logic i_mclk = 1'b0, i_rst_b = 1'b0, i_wake = 1'b0, i_freq_configured = 1'b0;
    logic [4:0]  i_startup_wait_setting = 5'h0;
    logic [15:0] i_ref_frequency_setting = 16'h0000, osc_khz;
    logic [1:0]  i_lock_source = 2'h0, o_loop_source;
    logic o_clk_request, o_fw_run, o_radio_enable, o_freq_supported, ref_clk;
    logic [15:0] o_ref_freq_khz;
    int num_errors = 0, checked = 0, cycles = 0;
    // Short millisecond keeps the run brief
    ref_clock_startup_config #(.CYC_PER_MS(CPM)) u_dut (.i_mclk(i_mclk), .i_rst_b(i_rst_b),
        .i_wake(i_wake), .i_startup_wait_setting(i_startup_wait_setting),
        .i_ref_frequency_setting(i_ref_frequency_setting), .i_freq_configured(i_freq_configured),
        .i_lock_source(i_lock_source), .o_clk_request(o_clk_request), .o_fw_run(o_fw_run),
        .o_radio_enable(o_radio_enable), .o_ref_freq_khz(o_ref_freq_khz),
        .o_freq_supported(o_freq_supported), .o_loop_source(o_loop_source));
    ref_osc_model u_osc (.i_clk_request(o_clk_request), .o_freq_khz(osc_khz), .o_ref_clk(ref_clk));
    // Edges of the modelled reference, to see it run only while requested
    int ref_edges = 0;
    always @(ref_clk) ref_edges++;
    // 20 MHz clock
    always #25 i_mclk = ~i_mclk;
    // Hang guard, well above three full start-ups
    always @(posedge i_mclk) begin
        cycles++;
        if (cycles > 5000) begin
            num_errors++;
            end_of_test();
        end
    end
    task automatic end_of_test();
        $display("checked %0d num_errors %0d", checked, num_errors);
        if (num_errors == 0 && checked > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask : end_of_test
    // Reset, then one full sequence with wait setting s expecting n ms
    task automatic t_startup(input logic [4:0] s, input int n);
        int cnt, edges;
        @(posedge i_mclk) i_rst_b <= 1'b0;
        i_wake <= 1'b0;
        i_startup_wait_setting <= s;
        repeat (5) @(posedge i_mclk);
        i_rst_b <= 1'b1;
        @(negedge i_mclk);
        `CHK("request_rst", 1'b0, o_clk_request)
        `CHK("run_rst", 1'b0, o_fw_run)
        edges = ref_edges;
        @(posedge i_mclk) i_wake <= 1'b1;
        `CHK("ref_idle", edges, ref_edges)
        @(posedge i_mclk);
        @(negedge i_mclk);
        `CHK("request_up", 1'b1, o_clk_request)
        cnt = 0;
        while (o_fw_run !== 1'b1 && cnt < 400) begin
            @(negedge i_mclk);
            cnt++;
        end
        `CHK("wait_len", 1'b1, cnt >= n * CPM - 1 && cnt <= n * CPM + 3)
        `CHK("request_hold", 1'b1, o_clk_request)
        `CHK("ref_run", 1'b1, ref_edges > edges)
        `CHK("radio_early", 1'b0, o_radio_enable)
        cnt = 0;
        while (o_radio_enable !== 1'b1 && cnt < 100) begin
            @(negedge i_mclk);
            cnt++;
        end
        `CHK("radio_len", 1'b1, cnt >= 6 * CPM - 1 && cnt <= 6 * CPM + 3)
    endtask : t_startup
    // Frequency setting table, defaults and source selection
    task automatic t_freq();
        int f[14] = '{14400, 15360, 16200, 16800, 19200, 19440, 19680, 19800, 38400,
                      12000, 52000, 12001, 52250, 11750};
        `CHK("freq_rst", 16'h6590, o_ref_freq_khz)
        for (int i = 0; i < 15; i++) begin
            @(posedge i_mclk) i_freq_configured <= (i < 14);
            i_ref_frequency_setting <= (i < 14) ? 16'(f[i % 14]) : osc_khz;
            @(posedge i_mclk);
            @(negedge i_mclk);
            `CHK("freq", (i < 14) ? 16'(f[i % 14]) : 16'h6590, o_ref_freq_khz)
            `CHK("supported", (i < 11) || (i == 14), o_freq_supported)
        end
        for (int s = 0; s < 4; s++) begin
            @(posedge i_mclk) i_lock_source <= 2'(s);
            @(posedge i_mclk);
            @(negedge i_mclk);
            `CHK("source", (s == 3) ? 2'h0 : 2'(s), o_loop_source)
        end
    endtask : t_freq
    // Main sequence
    initial begin
        t_startup(5'h00, 5);
        t_freq();
        t_startup(5'h01, 1);
        t_startup(5'h1f, 31);
        end_of_test();
    end
endmodule : tb_ref_clock_startup_config
